// ---- common/sebl_pkg.sv ----
// Constants and carrier types for the serial EEPROM boot loader.
// Assumes core_clk stands for the external system clock.
package sebl_pkg;

    // ------------------------------------------------------------
    // Clock division
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_FREQ_KHZ = 100000;
    localparam int unsigned SCK_FREQ_KHZ = 8330;
    localparam int unsigned SCK_DIV = SYS_CLK_FREQ_KHZ / SCK_FREQ_KHZ;

    // ------------------------------------------------------------
    // Mode select and protocol
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_EEPROM = 2'h1;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [15:0] START_ADDR = 16'h0000;
    localparam int unsigned HDR_BITS = 24;

    // ------------------------------------------------------------
    // Image layout
    // ------------------------------------------------------------
    localparam logic [8:0] GLOBAL_BASE = 9'h000;
    localparam logic [8:0] ARBITER_BASE = 9'h040;
    localparam logic [8:0] BERT_BASE = 9'h080;
    localparam logic [8:0] SER_TX_BASE = 9'h0C0;
    localparam logic [8:0] SER_RX_BASE = 9'h100;
    localparam logic [8:0] ETH_BASE = 9'h140;
    localparam logic [8:0] MAC_REC_BASE = 9'h180;
    localparam logic [8:0] IMAGE_LAST = 9'h19B;
    localparam int unsigned IMAGE_BYTES = 412;
    localparam int unsigned TOTAL_BITS = HDR_BITS + IMAGE_BYTES * 8;
    localparam int unsigned REGION_LSB = 6;

    // ------------------------------------------------------------
    // Indirect MAC write record
    // ------------------------------------------------------------
    localparam logic [2:0] REC_DATA0 = 3'h0;
    localparam logic [2:0] REC_DATA1 = 3'h1;
    localparam logic [2:0] REC_DATA2 = 3'h2;
    localparam logic [2:0] REC_DATA3 = 3'h3;
    localparam logic [2:0] REC_ADDR_LO = 3'h4;
    localparam logic [2:0] REC_ADDR_HI = 3'h5;
    localparam logic [2:0] REC_CMD = 3'h6;
    localparam logic [2:0] REC_COUNT = 3'h4;
    localparam logic [7:0] CMD_MAC_WRITE = 8'h01;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        REGION_GLOBAL,
        REGION_ARBITER,
        REGION_BERT,
        REGION_SER_TX,
        REGION_SER_RX,
        REGION_ETH,
        REGION_MAC_REC,
        REGION_NONE
    } sebl_region_t;

    typedef struct packed {
        logic valid;
        sebl_region_t region;
        logic [8:0] addr;
        logic [7:0] data;
    } sebl_cfg_wr_t;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [31:0] data;
    } sebl_mac_wr_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SELECT,
        ST_SHIFT,
        ST_FLUSH,
        ST_DONE
    } sebl_state_t;

endpackage : sebl_pkg

// ---- rtl/sebl_loader.sv ----
// Serial EEPROM boot loader: SPI master that reads the configuration
// image after reset and hands out direct and indirect MAC writes.
// Assumes core_clk is the system clock and the EEPROM sits on the pins.
//
// Behaviour
// - With the mode pins set to EEPROM, the block is SPI master and reads the image.
// - Master-out data changes on the rising or falling clock edge as configured.
// - Master-in data is sampled on the edge chosen by the phase select pin.
// - The serial clock is the system clock divided by twelve.
// - A load starts after power-up reset and after each rising edge of the reset pin.
// - Each access opens with the read instruction 0000x011b and the address.
// - Chip select stays low until every addressed byte is read and latched.
// - Reading starts at address 0000h and runs in sequence to the last image byte.
// - Image bytes below 180h map by 64-byte region onto the register groups.
// - Four seven-byte records at 180h to 19Bh carry indirect MAC writes.
// - Only the four MAC control and management registers are loaded this way.
// - The records sit at the image end and go through their own sequence.
// - Command byte 01h launches the indirect write of staged data and address.
// - Records start at base 180h and fields count from each record's base.
`timescale 1ns/1ps
module sebl_loader #(
    parameter int unsigned DIV_RATIO = sebl_pkg::SCK_DIV,
    parameter logic [1:0] EEPROM_MODE = sebl_pkg::MODE_EEPROM
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] config_source_select,
    input wire logic reset_pin_n,
    input wire logic sample_edge_select_pin,
    input wire logic mosi_rising_edge_sel,
    input wire logic spi_miso,
    output logic serial_boot_clock,
    output logic spi_cs_n,
    output logic spi_mosi,
    output sebl_pkg::sebl_cfg_wr_t cfg_wr,
    output sebl_pkg::sebl_mac_wr_t mac_wr,
    output logic load_busy,
    output logic load_done
);
    import sebl_pkg::*;

    localparam logic [3:0] DIV_LAST = 4'(DIV_RATIO - 1);
    localparam logic [3:0] HALF_LAST = 4'(DIV_RATIO / 2 - 1);
    localparam logic [11:0] LAST_BIT = 12'(TOTAL_BITS - 1);
    localparam logic [11:0] HDR_LEN = 12'(HDR_BITS);
    localparam logic [23:0] HDR_WORD = {CMD_READ, START_ADDR};

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] rstpin_sync_q;
    logic [2:0] phase_sync_q;
    logic [2:0] miso_sync_q;
    logic rstpin_lvl_q;
    logic phase_lvl_q;
    logic miso_lvl_q;
    logic rstpin_rise;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rstpin_sync_q <= 3'h7;
            phase_sync_q <= 3'h0;
            miso_sync_q <= 3'h0;
        end else begin
            rstpin_sync_q <= {rstpin_sync_q[1:0], reset_pin_n};
            phase_sync_q <= {phase_sync_q[1:0], sample_edge_select_pin};
            miso_sync_q <= {miso_sync_q[1:0], spi_miso};
        end
    end

    // Level counts once stages two and three agree
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rstpin_lvl_q <= 1'b1;
            phase_lvl_q <= 1'b0;
            miso_lvl_q <= 1'b0;
        end else begin
            if (rstpin_sync_q[1] == rstpin_sync_q[2]) begin
                rstpin_lvl_q <= rstpin_sync_q[2];
            end
            if (phase_sync_q[1] == phase_sync_q[2]) begin
                phase_lvl_q <= phase_sync_q[2];
            end
            if (miso_sync_q[1] == miso_sync_q[2]) begin
                miso_lvl_q <= miso_sync_q[2];
            end
        end
    end

    assign rstpin_rise = !rstpin_lvl_q && rstpin_sync_q[1]
                         && rstpin_sync_q[2];

    // ------------------------------------------------------------
    // Load request
    // ------------------------------------------------------------
    sebl_state_t state_q;
    logic start_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            start_q <= 1'b1;
        end else if (rstpin_rise) begin
            start_q <= 1'b1;
        end else if (state_q == ST_IDLE) begin
            start_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic [3:0] div_cnt_q;
    logic [11:0] bit_cnt_q;
    logic shifting;
    logic rise_ev;
    logic fall_ev;
    logic sample_ev;
    logic launch_ev;
    logic pin_held;

    assign shifting = (state_q == ST_SHIFT);
    assign rise_ev = shifting && (div_cnt_q == HALF_LAST);
    assign fall_ev = shifting && (div_cnt_q == DIV_LAST);
    assign sample_ev = phase_lvl_q ? rise_ev : fall_ev;
    assign launch_ev = mosi_rising_edge_sel ? rise_ev : fall_ev;
    assign pin_held = !rstpin_lvl_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
        end else if (pin_held) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_q) begin
                        if (config_source_select == EEPROM_MODE) begin
                            state_q <= ST_SELECT;
                        end else begin
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_SELECT: begin
                    state_q <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (fall_ev && bit_cnt_q == LAST_BIT) begin
                        state_q <= ST_FLUSH;
                    end
                end
                ST_FLUSH: begin
                    state_q <= ST_DONE;
                end
                ST_DONE: begin
                    if (start_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Divider and bit slot counters
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_cnt_q <= 4'h0;
            bit_cnt_q <= 12'h000;
        end else if (!shifting) begin
            div_cnt_q <= 4'h0;
            bit_cnt_q <= 12'h000;
        end else if (div_cnt_q == DIV_LAST) begin
            div_cnt_q <= 4'h0;
            bit_cnt_q <= bit_cnt_q + 12'h001;
        end else begin
            div_cnt_q <= div_cnt_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Serial pins
    // ------------------------------------------------------------
    function automatic logic hdr_bit(input logic [11:0] idx);
        logic [4:0] pos;
        pos = 5'(HDR_BITS - 1) - idx[4:0];
        hdr_bit = (idx < HDR_LEN) ? HDR_WORD[pos] : 1'b0;
    endfunction : hdr_bit

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            serial_boot_clock <= 1'b0;
        end else if (rise_ev) begin
            serial_boot_clock <= 1'b1;
        end else if (fall_ev || !shifting) begin
            serial_boot_clock <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            spi_mosi <= 1'b0;
        end else if (state_q == ST_SELECT) begin
            spi_mosi <= hdr_bit(12'h000);
        end else if (launch_ev) begin
            if (mosi_rising_edge_sel) begin
                spi_mosi <= hdr_bit(bit_cnt_q);
            end else begin
                spi_mosi <= hdr_bit(bit_cnt_q + 12'h001);
            end
        end
    end

    // Low from select until the last byte is latched
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            spi_cs_n <= 1'b1;
        end else begin
            spi_cs_n <= !(state_q == ST_SELECT || state_q == ST_SHIFT
                          || (state_q == ST_IDLE && start_q && !pin_held
                              && config_source_select == EEPROM_MODE));
        end
    end

    // ------------------------------------------------------------
    // Byte assembly
    // ------------------------------------------------------------
    logic [6:0] rx_sr_q;
    logic [2:0] rx_cnt_q;
    logic byte_ev;
    logic [7:0] rx_byte;

    assign byte_ev = sample_ev && (bit_cnt_q >= HDR_LEN)
                     && (rx_cnt_q == 3'h7);
    assign rx_byte = {rx_sr_q, miso_lvl_q};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rx_sr_q <= 7'h00;
            rx_cnt_q <= 3'h0;
        end else if (state_q == ST_SELECT) begin
            rx_sr_q <= 7'h00;
            rx_cnt_q <= 3'h0;
        end else if (sample_ev && bit_cnt_q >= HDR_LEN) begin
            rx_sr_q <= rx_byte[6:0];
            rx_cnt_q <= rx_cnt_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Direct copy of register groups
    // ------------------------------------------------------------
    logic [8:0] byte_addr_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            byte_addr_q <= 9'h000;
        end else if (state_q == ST_SELECT) begin
            byte_addr_q <= START_ADDR[8:0];
        end else if (byte_ev) begin
            byte_addr_q <= byte_addr_q + 9'h001;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_wr <= '0;
        end else begin
            cfg_wr.valid <= byte_ev && (byte_addr_q < MAC_REC_BASE);
            if (byte_ev && byte_addr_q < MAC_REC_BASE) begin
                cfg_wr.region <= sebl_region_t'(
                    byte_addr_q[8:REGION_LSB]);
                cfg_wr.addr <= byte_addr_q;
                cfg_wr.data <= rx_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // Indirect MAC write records
    // ------------------------------------------------------------
    logic [2:0] rec_off_q;
    logic [2:0] rec_cnt_q;
    logic [31:0] stage_data_q;
    logic [15:0] stage_addr_q;
    logic rec_byte;

    assign rec_byte = byte_ev && (byte_addr_q >= MAC_REC_BASE)
                      && (byte_addr_q <= IMAGE_LAST)
                      && (rec_cnt_q < REC_COUNT);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rec_off_q <= 3'h0;
            rec_cnt_q <= 3'h0;
        end else if (state_q == ST_SELECT) begin
            rec_off_q <= 3'h0;
            rec_cnt_q <= 3'h0;
        end else if (rec_byte) begin
            if (rec_off_q == REC_CMD) begin
                rec_off_q <= 3'h0;
                rec_cnt_q <= rec_cnt_q + 3'h1;
            end else begin
                rec_off_q <= rec_off_q + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage_data_q <= 32'h0000_0000;
            stage_addr_q <= 16'h0000;
        end else if (rec_byte) begin
            case (rec_off_q)
                REC_DATA0: stage_data_q[7:0] <= rx_byte;
                REC_DATA1: stage_data_q[15:8] <= rx_byte;
                REC_DATA2: stage_data_q[23:16] <= rx_byte;
                REC_DATA3: stage_data_q[31:24] <= rx_byte;
                REC_ADDR_LO: stage_addr_q[7:0] <= rx_byte;
                REC_ADDR_HI: stage_addr_q[15:8] <= rx_byte;
                default: begin
                end
            endcase
        end
    end

    // Launch only on the command byte, after the six staged bytes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mac_wr <= '0;
        end else begin
            mac_wr.valid <= rec_byte && rec_off_q == REC_CMD
                            && rx_byte == CMD_MAC_WRITE;
            if (rec_byte && rec_off_q == REC_CMD) begin
                mac_wr.addr <= stage_addr_q;
                mac_wr.data <= stage_data_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            load_busy <= 1'b0;
            load_done <= 1'b0;
        end else begin
            load_busy <= (state_q == ST_SELECT) || shifting
                         || (state_q == ST_FLUSH);
            load_done <= (state_q == ST_DONE) && !pin_held
                         && !start_q;
        end
    end

endmodule : sebl_loader

// ---- dv/sebl_loader_monitor.sv ----
// Concurrent checks on the boot loader top-level ports.
// Assumes one clock domain; the bind hands on the design's parameters.
`timescale 1ns/1ps
module sebl_loader_monitor #(
    parameter int unsigned DIV_RATIO = 12,
    parameter logic [1:0] EEPROM_MODE = 2'h1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] config_source_select,
    input wire logic reset_pin_n,
    input wire logic serial_boot_clock,
    input wire logic spi_cs_n,
    input wire sebl_pkg::sebl_cfg_wr_t cfg_wr,
    input wire sebl_pkg::sebl_mac_wr_t mac_wr
);
    import sebl_pkg::*;
    localparam int unsigned HALF = DIV_RATIO / 2;
    logic sck_q;
    logic seen_q;
    logic [15:0] run_q;
    logic [15:0] low_q;
    logic [15:0] gap_q;
    logic [8:0] exp_q;
    logic [2:0] mac_n_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sck_q <= 1'b0;
            run_q <= 16'h0000;
        end else begin
            sck_q <= serial_boot_clock;
            run_q <= (serial_boot_clock != sck_q) ? 16'h0001 : run_q + 16'h0001;
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || spi_cs_n) begin
            seen_q <= 1'b0;
            low_q <= 16'h0000;
            exp_q <= 9'h000;
            mac_n_q <= 3'h0;
        end else begin
            seen_q <= seen_q | serial_boot_clock;
            low_q <= low_q + 16'h0001;
            exp_q <= exp_q + {8'h00, cfg_wr.valid};
            mac_n_q <= mac_n_q + {2'h0, mac_wr.valid};
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst || mac_wr.valid) gap_q <= 16'h0000;
        else gap_q <= gap_q + 16'h0001;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_pin_restart;
        $rose(reset_pin_n) && config_source_select == EEPROM_MODE;
    endsequence
    property p_sck_high;
        $fell(serial_boot_clock) && !spi_cs_n |-> run_q == HALF;
    endproperty
    property p_sck_low;
        $rose(serial_boot_clock) && seen_q && !spi_cs_n |-> run_q == HALF;
    endproperty
    property p_cs_hold;
        $rose(spi_cs_n) && reset_pin_n |-> low_q >= 3320 * DIV_RATIO;
    endproperty
    property p_mode;
        $fell(spi_cs_n) |-> $past(config_source_select) == EEPROM_MODE;
    endproperty
    property p_por;
        $fell(rst) && reset_pin_n && config_source_select == EEPROM_MODE
            |-> ##[1:8] !spi_cs_n;
    endproperty
    property p_pin_load;
        s_pin_restart |-> ##[2:12] !spi_cs_n;
    endproperty
    property p_cfg_order;
        cfg_wr.valid |-> cfg_wr.addr == exp_q && cfg_wr.addr < 9'h180;
    endproperty
    property p_cfg_region;
        cfg_wr.valid |-> cfg_wr.region == sebl_region_t'(cfg_wr.addr[8:6]);
    endproperty
    property p_mac_after;
        mac_wr.valid |-> exp_q == 9'h180 && !spi_cs_n;
    endproperty
    property p_mac_gap;
        mac_wr.valid && mac_n_q != 3'h0
            |-> (gap_q + 16'h0001) % (56 * DIV_RATIO) == 0;
    endproperty
    property p_mac_count;
        mac_wr.valid |-> mac_n_q < 3'h4;
    endproperty
    a_sck_high: assert property (p_sck_high)
        else $error("serial clock high time wrong");
    a_sck_low: assert property (p_sck_low)
        else $error("serial clock low time wrong");
    a_cs_hold: assert property (p_cs_hold)
        else $error("chip select released early");
    a_mode: assert property (p_mode)
        else $error("transfer started outside EEPROM mode");
    a_por: assert property (p_por)
        else $error("no load after reset release");
    a_pin_load: assert property (p_pin_load)
        else $error("no load after reset pin rise");
    a_cfg_order: assert property (p_cfg_order)
        else $error("config write out of order");
    a_cfg_region: assert property (p_cfg_region)
        else $error("config write region wrong");
    a_mac_after: assert property (p_mac_after)
        else $error("MAC write before image body done");
    a_mac_gap: assert property (p_mac_gap)
        else $error("MAC write spacing wrong");
    a_mac_count: assert property (p_mac_count)
        else $error("more than four MAC writes");
endmodule : sebl_loader_monitor

bind sebl_loader sebl_loader_monitor #(
    .DIV_RATIO(DIV_RATIO), .EEPROM_MODE(EEPROM_MODE)
) u_mon (
    .core_clk, .rst, .config_source_select, .reset_pin_n,
    .serial_boot_clock, .spi_cs_n, .cfg_wr, .mac_wr
);

// ---- dv/sebl_eeprom_model.sv ----
// Behavioural serial EEPROM holding the configuration image.
// Assumes the bench loads mem and sets the edge choices while idle.
`timescale 1ns/1ps
module sebl_eeprom_model (
    input wire logic core_clk,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic drive_on_rise,
    input wire logic capture_on_rise,
    output logic miso,
    output logic [23:0] hdr
);
    logic [7:0] mem [0:411];
    int k = 0;
    int b;
    initial miso = 1'b0;
    initial hdr = 24'h000000;
    always @(negedge cs_n) k = 0;
    always @(sck) begin
        if (!cs_n) begin
            if (sck == capture_on_rise && k < 24) hdr = {hdr[22:0], mosi};
            if (!sck) k = k + 1;
            if (sck == drive_on_rise) begin
                b = k - 24;
                // Byte i of the image sits at address i
                if (k >= 24 && b < 3296) miso = mem[b / 8][7 - b % 8];
                else miso = ~miso;
            end
        end
    end
    // Released line shows no stale value
    always @(posedge core_clk) if (cs_n) miso <= ~miso;
endmodule : sebl_eeprom_model

// ---- dv/tb_sebl_loader.sv ----
// Self-checking bench for the serial EEPROM boot loader.
// Assumes the EEPROM model and the bound monitor are compiled alongside.
`timescale 1ns/1ps
module tb_sebl_loader;
    import sebl_pkg::*;
    localparam int unsigned DIV = 12;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] mode = MODE_EEPROM;
    logic pin_n = 1'b1;
    logic samp_sel = 1'b1;
    logic mosi_sel = 1'b0;
    logic spi_miso, sck, spi_cs_n, spi_mosi, load_busy, load_done;
    logic [23:0] hdr;
    sebl_cfg_wr_t cfg_wr;
    sebl_mac_wr_t mac_wr;
    logic [47:0] exp_mac [$];
    int failures = 0;
    int n_checks = 0;
    int n_cfg = 0;
    int n_mac = 0;
    int n_fall = 0;

    always #50 core_clk = ~core_clk;

    sebl_loader #(.DIV_RATIO(DIV)) uut (
        .core_clk(core_clk), .rst(rst), .config_source_select(mode),
        .reset_pin_n(pin_n), .sample_edge_select_pin(samp_sel),
        .mosi_rising_edge_sel(mosi_sel), .spi_miso(spi_miso),
        .serial_boot_clock(sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .cfg_wr(cfg_wr), .mac_wr(mac_wr), .load_busy(load_busy),
        .load_done(load_done)
    );
    sebl_eeprom_model eep (
        .core_clk(core_clk), .cs_n(spi_cs_n), .sck(sck), .mosi(spi_mosi),
        .drive_on_rise(!samp_sel), .capture_on_rise(!mosi_sel),
        .miso(spi_miso), .hdr(hdr)
    );
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cycles
    task automatic wait_done();
        for (int i = 0; i < 45000 && load_done !== 1'b1; i++) cycles(1);
        if (load_done !== 1'b1) begin
            failures++;
            $display("BAD load_done expected 1 seen %b", load_done);
            end_sim();
        end
    endtask : wait_done
    task automatic pulse_pin();
        pin_n <= 1'b0;
        cycles(10);
        pin_n <= 1'b1;
        cycles(10);
    endtask : pulse_pin
    // Random image; record bad gets a command other than write
    task automatic fill(input int bad);
        int o;
        for (int i = 0; i < 412; i++) eep.mem[i] = 8'($urandom);
        for (int r = 0; r < 4; r++) begin
            o = 384 + 7 * r;
            eep.mem[o + 6] = (r == bad) ? 8'h02 : CMD_MAC_WRITE;
            if (r != bad) exp_mac.push_back({eep.mem[o + 5], eep.mem[o + 4],
                eep.mem[o + 3], eep.mem[o + 2], eep.mem[o + 1], eep.mem[o]});
        end
    endtask : fill
    task automatic frame_end(input string name, input int nmac);
        chk("cfg_count", 384, n_cfg);
        chk("mac_count", nmac, n_mac);
        chk("header", {CMD_READ, START_ADDR}, hdr);
        chk("cs_idle", 1, spi_cs_n);
        $display("test %s done", name);
    endtask : frame_end
    // ------------------------------------------------------------
    // Output watchers
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (cfg_wr.valid === 1'b1) begin
            chk("cfg_addr", n_cfg, cfg_wr.addr);
            chk("cfg_data", eep.mem[n_cfg], cfg_wr.data);
            n_cfg++;
        end
        if (mac_wr.valid === 1'b1) begin
            chk("mac_wr", exp_mac.pop_front(), {mac_wr.addr, mac_wr.data});
            n_mac++;
        end
    end
    always @(negedge spi_cs_n) n_fall++;
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h7111));
        fill(4);
        cycles(2);
        rst <= 1'b0;
        wait_done();
        frame_end("power_up", 4);
        chk("frames", 1, n_fall);
        samp_sel <= 1'b0;
        mosi_sel <= 1'b1;
        fill(1);
        n_cfg = 0;
        n_mac = 0;
        pulse_pin();
        chk("busy", 1, load_busy);
        cycles(5000);
        pin_n <= 1'b0;
        cycles(10);
        chk("abort_cs", 1, spi_cs_n);
        n_cfg = 0;
        pin_n <= 1'b1;
        wait_done();
        frame_end("pin_restart", 3);
        for (int m = 0; m < 4; m++) begin
            if (2'(m) != MODE_EEPROM) begin
                mode <= 2'(m);
                n_fall = 0;
                pulse_pin();
                wait_done();
                chk("no_frame", 0, n_fall);
            end
        end
        $display("test other_modes done");
        end_sim();
    end
endmodule : tb_sebl_loader
